// ===== core/pmc_pkg.sv
// package: constants and types for the power mode controller
package pmc_pkg;
  localparam int unsigned clk_mhz = 25;
  localparam int unsigned sleep_wake_us = 25;
  localparam int unsigned hib_wake_us = 200;
  // longest times round down
  localparam int unsigned sleep_wake_cycles = sleep_wake_us * clk_mhz;
  localparam int unsigned hib_wake_cycles = hib_wake_us * clk_mhz;
  localparam logic [12:0] sleep_wake_cnt = 13'(sleep_wake_cycles - 1);
  localparam logic [12:0] hib_wake_cnt = 13'(hib_wake_cycles - 1);
  // low-speed oscillator tick and regulator buzz rates
  localparam logic [15:0] lso_div = 16'h61A7;
  localparam logic [3:0] buzz_period = 4'hF;
  localparam logic [3:0] buzz_on = 4'h3;
  localparam int unsigned sub_n = 8;
  // register byte offsets
  localparam logic [11:0] off_mode = 12'h000;
  localparam logic [11:0] off_act_tpl = 12'h004;
  localparam logic [11:0] off_alt_tpl = 12'h008;
  localparam logic [11:0] off_reg_ctl = 12'h00C;
  localparam logic [11:0] off_irq_stat = 12'h010;
  localparam logic [11:0] off_irq_clr = 12'h014;
  localparam logic [11:0] off_irq_en = 12'h018;
  localparam logic [11:0] off_tw_ctl = 12'h01C;
  localparam logic [11:0] off_tw_cnt = 12'h020;
  localparam logic [7:0] act_tpl_rst = 8'hFF;
  localparam logic [7:0] alt_tpl_rst = 8'hFE;
  localparam logic [12:0] tw_period_rst = 13'h03FF;
  localparam int unsigned cpu_bit = 0;
  // wake source bit positions
  localparam int unsigned wk_cmp = 0;
  localparam int unsigned wk_piu = 1;
  localparam int unsigned wk_i2c = 2;
  localparam int unsigned wk_rtc = 3;
  localparam int unsigned wk_tw = 4;
  localparam int unsigned wk_lvd = 5;
  localparam int unsigned wk_irq = 6;
  localparam int unsigned ev_n = 7;

  typedef enum logic [1:0] {
    mode_active = 2'b00,
    mode_alt_active = 2'b01,
    mode_sleep = 2'b10,
    mode_hibernate = 2'b11
  } mode_e;

  typedef enum logic [1:0] {
    st_run = 2'b00,
    st_low = 2'b01,
    st_wake = 2'b10
  } state_e;

  typedef struct packed {
    logic dig_reg_en;
    logic ana_reg_en;
    logic dig_reg_buzz;
    logic ana_reg_buzz;
    logic hib_reg_en;
  } regulator_s;

  typedef struct packed {
    logic comparator;
    logic port_interrupt_unit;
    logic i2c_match;
    logic rtc;
    logic low_voltage_detect;
    logic any_irq;
  } wake_s;

  typedef struct packed {
    logic external_reset_pin;
    logic low_voltage_detect;
    logic watchdog_reset;
  } rst_src_s;
endpackage

// ===== core/power_mode_controller.sv
// power mode controller with apb registers, wake sequencing and regulator control
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
//Behaviour
//RULE1 - four modes: active, alternate active, sleep, hibernate
//RULE2 - active and alternate active each use a per-subsystem enable template
//RULE3 - a disabled subsystem has clock gated, bias off, leakage reduced
//RULE4 - sleep disables everything except timewheel and rtc on slow clocks
//RULE5 - active entered by wake, reset or write; any interrupt wakes
//RULE6 - alternate active uses its own template, entered by write only
//RULE7 - sleep wakes on comparator, port unit, i2c, rtc, timewheel, voltage detect
//RULE8 - wake within 25 us from sleep, 200 us from hibernate; reset sources per mode
//RULE9 - hibernate stops all clocks, keeps state, wakes only on port unit
//RULE10 - hibernate disables peripherals and regulators except hibernate regulator
//RULE11 - sleep runs both core regulators duty cycled
//RULE12 - in hibernate only the hibernate regulator stays on
//RULE13 - core regulators enabled after power-up, firmware may disable them
//RULE14 - cpu may disable itself and is re-enabled on next wake
//RULE15 - any wake returns to active and enables the cpu
//RULE16 - start in active after boot
//RULE17 - timewheel is free-running 13-bit counter on slow oscillator tick
//RULE18 - current mode readable; requested mode acted on only when permitted
module power_mode_controller (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pmc_pkg::wake_s wake_in,
  input wire pmc_pkg::rst_src_s rst_in,
  output pmc_pkg::mode_e mode,
  output logic [7:0] sub_clk_en,
  output logic [7:0] sub_bias_en,
  output logic cpu_en,
  output logic lso_clk_en,
  output logic rtc_en,
  output pmc_pkg::regulator_s regulators,
  output logic system_reset,
  output logic irq
);
  typedef struct packed {
    pmc_pkg::mode_e mode;
    pmc_pkg::state_e state;
    logic [7:0] act_tpl;
    logic [7:0] alt_tpl;
    logic dig_reg_on;
    logic ana_reg_on;
    logic cpu_off;
    logic [12:0] wake_cnt;
    logic [15:0] lso_cnt;
    logic lso_tick;
    logic [3:0] buzz_cnt;
    logic [12:0] tw_cnt;
    logic [12:0] tw_period;
    logic [6:0] irq_stat;
    logic [6:0] irq_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pmc_pkg::mode_e out_mode;
    logic [7:0] sub_en;
    logic cpu_en;
    logic lso_en;
    pmc_pkg::regulator_s regs;
    logic sys_rst;
    logic irq;
  } state_s;

  state_s s_reg;
  state_s s_next;

  function automatic logic [31:0] word(input logic [12:0] v);
    word = {19'h0_0000, v};
  endfunction

  logic wr;
  logic rd;
  logic [6:0] events;
  logic wake_now;
  logic rst_now;
  logic tw_hit;

  always_comb begin
    s_next = s_reg;
    wr = psel && penable && pwrite && !s_reg.pready;
    rd = psel && penable && !pwrite && !s_reg.pready;
    s_next.pready = psel && penable && !s_reg.pready;
    s_next.pslverr = 1'b0;
    s_next.prdata = 32'h0000_0000;
    // slow oscillator tick from the system clock divider
    s_next.lso_tick = 1'b0;
    s_next.lso_cnt = s_reg.lso_cnt + 16'h0001;
    if (s_reg.lso_cnt == pmc_pkg::lso_div) begin
      s_next.lso_cnt = 16'h0000;
      s_next.lso_tick = 1'b1;
    end
    // timewheel frozen in hibernate: no clocks there
    tw_hit = 1'b0;
    if (s_reg.lso_tick && s_reg.mode != pmc_pkg::mode_hibernate) begin
      s_next.tw_cnt = s_reg.tw_cnt + 13'h0001; // see RULE17
      tw_hit = (s_reg.tw_cnt == s_reg.tw_period);
    end
    events = {wake_in.any_irq, wake_in.low_voltage_detect, tw_hit, wake_in.rtc,
              wake_in.i2c_match, wake_in.port_interrupt_unit, wake_in.comparator};
    // filter by mode
    case (s_reg.mode)
      pmc_pkg::mode_active, pmc_pkg::mode_alt_active: wake_now = |events; // see RULE5
      pmc_pkg::mode_sleep: wake_now = |events[5:0]; // see RULE7
      pmc_pkg::mode_hibernate: wake_now = events[pmc_pkg::wk_piu]; // see RULE9
      default: wake_now = 1'b0;
    endcase
    case (s_reg.mode)
      pmc_pkg::mode_sleep: rst_now = |rst_in; // see RULE8
      pmc_pkg::mode_hibernate: rst_now = rst_in.external_reset_pin; // see RULE8
      default: rst_now = |rst_in;
    endcase
    // set beats clear
    if (wr && paddr == pmc_pkg::off_irq_clr) begin
      s_next.irq_stat = s_reg.irq_stat & ~pwdata[6:0];
    end
    s_next.irq_stat = s_next.irq_stat | events;
    s_next.sys_rst = rst_now;
    case (s_reg.state)
      pmc_pkg::st_run: begin
        if (wake_now || rst_now) begin
          s_next.mode = pmc_pkg::mode_active; // see RULE15
          s_next.cpu_off = 1'b0; // see RULE14
        end else if (wr && paddr == pmc_pkg::off_mode) begin
          s_next.cpu_off = pwdata[8]; // see RULE14
          case (pwdata[1:0]) // see RULE18
            2'b00: s_next.mode = pmc_pkg::mode_active; // see RULE5
            2'b01: s_next.mode = pmc_pkg::mode_alt_active; // see RULE6
            2'b10: begin
              s_next.mode = pmc_pkg::mode_sleep;
              s_next.state = pmc_pkg::st_low;
            end
            default: begin
              s_next.mode = pmc_pkg::mode_hibernate;
              s_next.state = pmc_pkg::st_low;
            end
          endcase
        end
      end
      pmc_pkg::st_low: begin
        if (wake_now || rst_now) begin
          s_next.state = pmc_pkg::st_wake;
          s_next.wake_cnt = (s_reg.mode == pmc_pkg::mode_sleep) ?
              pmc_pkg::sleep_wake_cnt : pmc_pkg::hib_wake_cnt; // see RULE8
        end
      end
      pmc_pkg::st_wake: begin
        // core regulators keep their sleep or hibernate setting until active is declared
        if (s_reg.wake_cnt == 13'h0000) begin
          s_next.state = pmc_pkg::st_run;
          s_next.mode = pmc_pkg::mode_active; // see RULE15
          s_next.cpu_off = 1'b0;
        end else begin
          s_next.wake_cnt = s_reg.wake_cnt - 13'h0001;
        end
      end
      default: s_next.state = pmc_pkg::st_run;
    endcase
    if (wr) begin
      case (paddr)
        pmc_pkg::off_act_tpl: s_next.act_tpl = pwdata[7:0]; // see RULE2
        pmc_pkg::off_alt_tpl: s_next.alt_tpl = pwdata[7:0]; // see RULE2
        pmc_pkg::off_reg_ctl: begin
          s_next.dig_reg_on = pwdata[0]; // see RULE13
          s_next.ana_reg_on = pwdata[1];
        end
        pmc_pkg::off_irq_en: s_next.irq_en = pwdata[6:0];
        pmc_pkg::off_tw_ctl: begin
          s_next.tw_period = pwdata[12:0];
          if (pwdata[16]) begin
            s_next.tw_cnt = 13'h0000;
          end
        end
        pmc_pkg::off_mode, pmc_pkg::off_irq_clr: ;
        default: s_next.pslverr = 1'b1;
      endcase
    end
    if (rd) begin
      case (paddr)
        pmc_pkg::off_mode: s_next.prdata = {23'h00_0000, s_reg.cpu_off, 4'h0,
            s_reg.state, s_reg.mode}; // see RULE18
        pmc_pkg::off_act_tpl: s_next.prdata = {24'h00_0000, s_reg.act_tpl};
        pmc_pkg::off_alt_tpl: s_next.prdata = {24'h00_0000, s_reg.alt_tpl};
        pmc_pkg::off_reg_ctl: s_next.prdata = {30'h0000_0000, s_reg.ana_reg_on,
            s_reg.dig_reg_on};
        pmc_pkg::off_irq_stat: s_next.prdata = {25'h000_0000, s_reg.irq_stat};
        pmc_pkg::off_irq_en: s_next.prdata = {25'h000_0000, s_reg.irq_en};
        pmc_pkg::off_tw_ctl: s_next.prdata = word(s_reg.tw_period);
        pmc_pkg::off_tw_cnt: s_next.prdata = word(s_reg.tw_cnt);
        pmc_pkg::off_irq_clr: s_next.prdata = 32'h0000_0000;
        default: s_next.pslverr = 1'b1;
      endcase
    end
    // a wake re-arms the cpu bit, so the cpu stays on after the wake too
    if ((s_reg.state == pmc_pkg::st_run && (wake_now || rst_now)) ||
        (s_reg.state == pmc_pkg::st_wake && s_reg.wake_cnt == 13'h0000)) begin
      s_next.act_tpl[pmc_pkg::cpu_bit] = 1'b1; // see RULE15
    end
    // outputs follow the state that is being registered
    s_next.buzz_cnt = (s_reg.buzz_cnt == pmc_pkg::buzz_period) ? 4'h0 :
        s_reg.buzz_cnt + 4'h1;
    s_next.out_mode = s_next.mode;
    s_next.lso_en = 1'b1;
    s_next.regs = '{dig_reg_en: s_next.dig_reg_on, ana_reg_en: s_next.ana_reg_on,
        dig_reg_buzz: 1'b0, ana_reg_buzz: 1'b0, hib_reg_en: 1'b1};
    case (s_next.mode) // see RULE1
      pmc_pkg::mode_active: begin
        s_next.sub_en = s_next.act_tpl; // see RULE3
        s_next.cpu_en = s_next.act_tpl[pmc_pkg::cpu_bit] && !s_next.cpu_off;
      end
      pmc_pkg::mode_alt_active: begin
        s_next.sub_en = s_next.alt_tpl; // see RULE6
        s_next.cpu_en = s_next.alt_tpl[pmc_pkg::cpu_bit] && !s_next.cpu_off;
      end
      pmc_pkg::mode_sleep: begin
        s_next.sub_en = 8'h00; // see RULE4
        s_next.cpu_en = 1'b0;
        // duty cycled regulators, limited by software disables
        s_next.regs.dig_reg_en = s_next.dig_reg_on && (s_reg.buzz_cnt < pmc_pkg::buzz_on);
        s_next.regs.ana_reg_en = s_next.ana_reg_on && (s_reg.buzz_cnt < pmc_pkg::buzz_on);
        s_next.regs.dig_reg_buzz = 1'b1; // see RULE11
        s_next.regs.ana_reg_buzz = 1'b1;
      end
      default: begin
        s_next.sub_en = 8'h00; // see RULE10
        s_next.cpu_en = 1'b0;
        s_next.lso_en = 1'b0; // see RULE9
        s_next.regs.dig_reg_en = 1'b0; // see RULE12
        s_next.regs.ana_reg_en = 1'b0;
      end
    endcase
    // wake completes: cpu forced on regardless of its template bit
    if (s_next.mode == pmc_pkg::mode_active && s_next.state == pmc_pkg::st_run &&
        s_reg.state == pmc_pkg::st_wake) begin
      s_next.cpu_en = 1'b1;
    end
    s_next.irq = |(s_next.irq_stat & s_next.irq_en);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_reg <= '0;
      s_reg.mode <= pmc_pkg::mode_active; // see RULE16
      s_reg.out_mode <= pmc_pkg::mode_active;
      s_reg.state <= pmc_pkg::st_run;
      s_reg.act_tpl <= pmc_pkg::act_tpl_rst;
      s_reg.alt_tpl <= pmc_pkg::alt_tpl_rst;
      s_reg.sub_en <= pmc_pkg::act_tpl_rst;
      s_reg.cpu_en <= 1'b1;
      s_reg.lso_en <= 1'b1;
      s_reg.dig_reg_on <= 1'b1; // see RULE13
      s_reg.ana_reg_on <= 1'b1;
      s_reg.regs <= 5'b11001;
      s_reg.tw_period <= pmc_pkg::tw_period_rst;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign mode = s_reg.out_mode;
  assign sub_clk_en = s_reg.sub_en;
  assign sub_bias_en = s_reg.sub_en;
  assign cpu_en = s_reg.cpu_en;
  assign lso_clk_en = s_reg.lso_en;
  assign rtc_en = s_reg.lso_en;
  assign regulators = s_reg.regs;
  assign system_reset = s_reg.sys_rst;
  assign irq = s_reg.irq;

  property p_sleep_gates;
    @(posedge clk) disable iff (reset) mode == pmc_pkg::mode_sleep |-> sub_clk_en == 8'h00 && !cpu_en;
  endproperty
  a_sleep_gates: assert property (p_sleep_gates) else $error("sleep left a subsystem on"); // see RULE4

  property p_hib_regs;
    @(posedge clk) disable iff (reset) mode == pmc_pkg::mode_hibernate |->
        regulators.hib_reg_en && !regulators.dig_reg_en && !regulators.ana_reg_en && !lso_clk_en;
  endproperty
  a_hib_regs: assert property (p_hib_regs) else $error("hibernate regulator state wrong"); // see RULE12

  property p_sleep_wake_bound;
    @(posedge clk) disable iff (reset) (s_reg.state == pmc_pkg::st_low && s_reg.mode ==
        pmc_pkg::mode_sleep && wake_now) |-> ##[1:626] mode == pmc_pkg::mode_active;
  endproperty
  a_sleep_wake_bound: assert property (p_sleep_wake_bound) else $error("sleep wake too slow"); // see RULE8

  property p_hib_only_piu;
    @(posedge clk) disable iff (reset) (s_reg.state == pmc_pkg::st_low && s_reg.mode ==
        pmc_pkg::mode_hibernate && !wake_in.port_interrupt_unit && !rst_in.external_reset_pin)
        |=> s_reg.state == pmc_pkg::st_low;
  endproperty
  a_hib_only_piu: assert property (p_hib_only_piu) else $error("hibernate woke wrongly"); // see RULE9

  property p_wake_cpu;
    @(posedge clk) disable iff (reset) (s_reg.state == pmc_pkg::st_wake && s_reg.wake_cnt == 13'h0000)
        |=> mode == pmc_pkg::mode_active && cpu_en;
  endproperty
  a_wake_cpu: assert property (p_wake_cpu) else $error("wake did not enable cpu"); // see RULE15

  property p_act_tpl;
    @(posedge clk) disable iff (reset) mode == pmc_pkg::mode_active |-> sub_clk_en == s_reg.act_tpl;
  endproperty
  a_act_tpl: assert property (p_act_tpl) else $error("active template not applied"); // see RULE2

  property p_tw_count;
    @(posedge clk) disable iff (reset) (s_reg.lso_tick && s_reg.mode != pmc_pkg::mode_hibernate
        && !wr) |=> s_reg.tw_cnt == $past(s_reg.tw_cnt) + 13'h0001;
  endproperty
  a_tw_count: assert property (p_tw_count) else $error("timewheel did not advance"); // see RULE17

  property p_sleep_buzz;
    @(posedge clk) disable iff (reset) mode == pmc_pkg::mode_sleep |-> regulators.dig_reg_buzz &&
        regulators.ana_reg_buzz;
  endproperty
  a_sleep_buzz: assert property (p_sleep_buzz) else $error("sleep regulators not buzzed"); // see RULE11

  property p_alt_tpl;
    @(posedge clk) disable iff (reset) mode == pmc_pkg::mode_alt_active |-> sub_clk_en == s_reg.alt_tpl;
  endproperty
  a_alt_tpl: assert property (p_alt_tpl) else $error("alternate template not applied"); // see RULE6

  property p_run_wake;
    @(posedge clk) disable iff (reset) (s_reg.state == pmc_pkg::st_run && wake_now)
        |=> mode == pmc_pkg::mode_active && cpu_en;
  endproperty
  a_run_wake: assert property (p_run_wake) else $error("run wake left cpu off"); // see RULE15

  property p_hib_rst;
    @(posedge clk) disable iff (reset) (s_reg.mode == pmc_pkg::mode_hibernate &&
        !rst_in.external_reset_pin) |=> !system_reset;
  endproperty
  a_hib_rst: assert property (p_hib_rst) else $error("hibernate took a wrong reset"); // see RULE8

  property p_irq_level;
    @(posedge clk) disable iff (reset) irq == |(s_reg.irq_stat & s_reg.irq_en);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong"); // see RULE5
endmodule

// ===== tb/event_sources.sv
// model of the on-chip wake and reset event sources
`timescale 1ns/1ps
module event_sources (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [3:0] cmd_kind,
  input wire logic [7:0] cmd_len,
  output pmc_pkg::wake_s wake_in,
  output pmc_pkg::rst_src_s rst_in
);
  logic [7:0] left_reg;
  logic [3:0] kind_reg;
  logic [8:0] lines;
  // length 1 is a prompt pulse, longer lengths a slow level
  always_ff @(posedge clk) begin
    if (reset) begin
      left_reg <= 8'h00;
      kind_reg <= 4'h0;
    end else if (cmd_valid) begin
      left_reg <= cmd_len;
      kind_reg <= cmd_kind;
    end else if (left_reg != 8'h00) begin
      left_reg <= left_reg - 8'h01;
    end
  end
  assign lines = (left_reg != 8'h00) ? (9'h100 >> kind_reg) : 9'h000;
  assign wake_in = lines[8:3];
  assign rst_in = lines[2:0];
endmodule

// ===== tb/testbench.sv
// self-checking bench for the power mode controller
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pmc_pkg::wake_s wake_in;
  pmc_pkg::rst_src_s rst_in;
  pmc_pkg::mode_e mode;
  logic [7:0] sub_clk_en;
  logic [7:0] sub_bias_en;
  logic cpu_en;
  logic lso_clk_en;
  logic rtc_en;
  pmc_pkg::regulator_s regulators;
  logic system_reset;
  logic irq;
  logic cmd_valid = 1'b0;
  logic [3:0] cmd_kind = 4'h0;
  logic [7:0] cmd_len = 8'h00;
  logic [31:0] seed = 32'h0000_d67e;
  logic [31:0] rdat;
  logic perr;
  logic seen;
  logic [7:0] atpl;
  int mismatches = 0;
  int total_checks = 0;
  int n;

  always #20 clk = ~clk;

  power_mode_controller u_power_mode_controller (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_in(wake_in), .rst_in(rst_in), .mode(mode),
    .sub_clk_en(sub_clk_en), .sub_bias_en(sub_bias_en), .cpu_en(cpu_en),
    .lso_clk_en(lso_clk_en), .rtc_en(rtc_en), .regulators(regulators),
    .system_reset(system_reset), .irq(irq));

  event_sources u_event_sources (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_len(cmd_len), .wake_in(wake_in), .rst_in(rst_in));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  function automatic logic [7:0] subs_expect(input logic [1:0] md, input logic [7:0] tpl);
    return md[1] ? 8'h00 : tpl;
  endfunction

  function automatic int wake_bound(input logic [1:0] md);
    return md[0] ? int'(pmc_pkg::hib_wake_cycles) + 4 : int'(pmc_pkg::sleep_wake_cycles) + 4;
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk(k < 20, 1'b1, "apb answer");
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic fire(input logic [3:0] k, input logic [7:0] len);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_len <= len;
    @(posedge clk);
    cmd_valid <= 1'b0;
  endtask

  task automatic wait_mode(input logic [1:0] m, input int lim);
    n = 0;
    while (mode !== m && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(mode, m, "mode reached in time");
  endtask

  task automatic rst_watch(input int lim);
    seen = 1'b0;
    repeat (lim) begin
      @(posedge clk);
      if (system_reset === 1'b1) seen = 1'b1;
    end
  endtask

  task automatic set_mode(input logic [31:0] v);
    apb(1'b1, pmc_pkg::off_mode, v);
    repeat (3) @(posedge clk);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    results();
  end

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(mode, 2'b00, "boot mode");
    chk({cpu_en, sub_clk_en, regulators}, {1'b1, 8'hFF, 5'h19}, "boot outputs");
    for (int i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      atpl = {seed[7:1], 1'b0};
      apb(1'b1, pmc_pkg::off_act_tpl, {24'h00_0000, atpl});
      repeat (3) @(posedge clk);
      chk(sub_clk_en[7:1], subs_expect(2'b00, atpl) >> 1, "clock gates");
      chk(sub_bias_en[7:1], subs_expect(2'b00, atpl) >> 1, "bias gates");
      apb(1'b0, pmc_pkg::off_act_tpl, 32'h0000_0000);
      chk(rdat, {24'h00_0000, atpl}, "template readback");
    end
    $display("test templates done");
    set_mode(32'h0000_0001);
    chk(mode, 2'b01, "alt entry");
    chk(sub_clk_en[7:1], pmc_pkg::alt_tpl_rst[7:1], "alt template");
    apb(1'b0, pmc_pkg::off_mode, 32'h0000_0000);
    chk(rdat[1:0], 2'b01, "mode readback");
    fire(4'h5, 8'h01);
    wait_mode(2'b00, 4);
    repeat (3) @(posedge clk);
    chk(cpu_en, 1'b1, "cpu on after wake");
    apb(1'b1, pmc_pkg::off_act_tpl, 32'h0000_00FF);
    set_mode(32'h0000_0100);
    chk(cpu_en, 1'b0, "cpu self off");
    fire(4'h5, 8'h03);
    repeat (5) @(posedge clk);
    chk(cpu_en, 1'b1, "cpu back on");
    $display("test run modes done");
    for (int k = 0; k < 5; k++) begin
      set_mode(32'h0000_0002);
      chk(sub_clk_en, 8'h00, "sleep gates");
      chk({lso_clk_en, rtc_en}, 2'b11, "sleep clocks");
      if (k == 0) begin
        n = 0;
        repeat (16) begin
          @(posedge clk);
          n += regulators.dig_reg_en;
        end
        chk(n > 0 && n < 16, 1'b1, "regulator duty cycle");
        set_mode(32'h0000_0001);
        chk(mode, 2'b10, "write ignored in sleep");
      end
      seed = xorshift(seed);
      fire(k[3:0], {5'h00, seed[2:0]} + 8'h01);
      wait_mode(2'b00, wake_bound(2'b10));
    end
    set_mode(32'h0000_0002);
    fire(4'h5, 8'h01);
    repeat (700) @(posedge clk);
    chk(mode, 2'b10, "interrupt ignored in sleep");
    apb(1'b0, pmc_pkg::off_tw_cnt, 32'h0000_0000);
    apb(1'b1, pmc_pkg::off_tw_ctl, {19'h0_0000, rdat[12:0] + 13'h0001});
    wait_mode(2'b00, 51000);
    apb(1'b0, pmc_pkg::off_irq_stat, 32'h0000_0000);
    chk(rdat[4], 1'b1, "timewheel status");
    $display("test sleep done");
    apb(1'b1, pmc_pkg::off_irq_en, 32'h0000_007F);
    apb(1'b1, pmc_pkg::off_irq_clr, 32'h0000_007F);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "irq cleared");
    fire(4'h3, 8'h01);
    repeat (3) @(posedge clk);
    chk(irq, 1'b1, "irq raised");
    apb(1'b1, pmc_pkg::off_irq_en, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "irq masked");
    apb(1'b0, pmc_pkg::off_irq_stat, 32'h0000_0000);
    chk(rdat[3], 1'b1, "status stays set");
    apb(1'b0, 12'h024, 32'h0000_0000);
    chk(perr, 1'b1, "unmapped offset");
    apb(1'b1, pmc_pkg::off_reg_ctl, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk({regulators.dig_reg_en, regulators.ana_reg_en}, 2'b00, "regulators off");
    apb(1'b1, pmc_pkg::off_reg_ctl, 32'h0000_0003);
    $display("test registers done");
    set_mode(32'h0000_0003);
    chk(regulators, 5'h01, "hibernate regulator only");
    chk({sub_clk_en, lso_clk_en, rtc_en}, 10'h000, "hibernate clocks");
    fire(4'h3, 8'h01);
    fire(4'h0, 8'h04);
    repeat (5100) @(posedge clk);
    chk(mode, 2'b11, "hibernate holds");
    fire(4'h1, 8'h02);
    wait_mode(2'b00, wake_bound(2'b11));
    $display("test hibernate done");
    set_mode(32'h0000_0002);
    fire(4'h8, 8'h01);
    rst_watch(6);
    chk(seen, 1'b1, "watchdog reset in sleep");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    set_mode(32'h0000_0003);
    fire(4'h8, 8'h01);
    rst_watch(6);
    chk(seen, 1'b0, "watchdog ignored in hibernate");
    fire(4'h6, 8'h01);
    rst_watch(6);
    chk(seen, 1'b1, "pin reset in hibernate");
    $display("test reset sources done");
    results();
  end
endmodule
